// >>> verilog/codec_timing.sv
// codec conversion timing and serial word control
`timescale 1ns/100ps
`default_nettype none

module conv_timer (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // divisors
  input wire logic [codec_pkg::A_W-1:0] i_base,
  input wire logic [codec_pkg::ADJ_W-1:0] i_adj,
  input wire logic [codec_pkg::B_W-1:0] i_second,
  // control code from a primary word
  input wire logic i_code_set,
  input wire logic [1:0] i_code,
  // timing
  output logic o_filter_clk,
  output logic o_conv
);
  logic [codec_pkg::CNT_A_W-1:0] cnt_a_reg;
  logic [codec_pkg::B_W-1:0] cnt_b_reg;
  logic [1:0] code_reg;
  logic [7:0] base_ext;
  logic [7:0] adj_ext;
  logic [7:0] sum;
  logic [codec_pkg::CNT_A_W-1:0] adj_load;
  logic tick_a;
  logic conv;

  // ----------------------------------------
  // adjusted reload value
  // ----------------------------------------
  always_comb begin
    base_ext = {3'h0, i_base};
    adj_ext = {{2{i_adj[codec_pkg::ADJ_W-1]}}, i_adj};
    sum = (code_reg == codec_pkg::CODE_MINUS) ? base_ext - adj_ext : base_ext + adj_ext;
    adj_load = base_ext[6:0];
    if (code_reg == codec_pkg::CODE_PLUS || code_reg == codec_pkg::CODE_MINUS) begin
      if (sum[7]) begin
        adj_load = 7'(sum + codec_pkg::MOD64);
      end else if (sum > 8'h01) begin
        adj_load = sum[6:0];
      end
    end
  end

  assign tick_a = cnt_a_reg <= 7'h01;
  assign conv = tick_a && o_filter_clk && cnt_b_reg <= 6'h01;

  // ----------------------------------------
  // counter pair
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt_a_reg <= {2'h0, codec_pkg::RST_BASE};
    end else if (conv) begin
      cnt_a_reg <= adj_load;
    end else if (tick_a) begin
      cnt_a_reg <= base_ext[6:0];
    end else begin
      cnt_a_reg <= cnt_a_reg - 7'h01;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_filter_clk <= 1'b0;
    end else if (tick_a) begin
      o_filter_clk <= ~o_filter_clk;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt_b_reg <= codec_pkg::RST_SECOND;
    end else if (tick_a && o_filter_clk) begin
      cnt_b_reg <= (cnt_b_reg <= 6'h01) ? i_second : cnt_b_reg - 6'h01;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      code_reg <= codec_pkg::CODE_BASE;
      o_conv <= 1'b0;
    end else begin
      o_conv <= conv;
      if (i_code_set) begin
        code_reg <= i_code;
      end else if (conv) begin
        code_reg <= codec_pkg::CODE_BASE;
      end
    end
  end
endmodule // conv_timer

module codec_timing (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // serial link
  codec_link_if.codec link,
  // converters
  input wire logic [15:0] i_adc_sample,
  output logic [codec_pkg::DAC_W-1:0] o_dac_sample,
  output logic o_dac_update,
  output logic o_tx_conv,
  output logic o_rx_conv,
  // filter clocks
  output logic o_tx_filter_clk,
  output logic o_rx_filter_clk,
  output logic o_hp_filter_clk,
  // configuration
  output logic o_sinx_on,
  output logic [1:0] o_gain,
  output logic o_sync_mode,
  output logic o_aux_on,
  output logic o_loopback,
  output logic o_hp_on
);
  logic [1:0] phase_reg;
  logic shift_clk_reg;
  logic samp_en, bit_en, sync;
  logic [4:0] tx_base_divisor, rx_base_divisor;
  logic [5:0] tx_adjust_value, rx_adjust_value, tx_second_divisor, rx_second_divisor;
  logic [codec_pkg::CTRL_W-1:0] ctrl_reg;
  codec_pkg::tx_state_t tx_st;
  logic [3:0] tx_bits_reg, rx_bits_reg;
  logic [1:0] gap_reg;
  logic is_sec_reg, tx_pend_reg, rx_pend_reg, rx_active_reg;
  logic [15:0] tx_sh_reg, dr_sh_reg;
  logic fsx_n_reg, fsr_n_reg, tx_eod_n_reg, rx_eod_n_reg;
  logic tx_start, rx_start, word_end, code_set;
  logic tx_fclk, rx_fclk, tx_conv, rx_path_conv, rx_conv;

  // ----------------------------------------
  // shift clock divider
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      phase_reg <= 2'h0;
      shift_clk_reg <= 1'b1;
    end else begin
      phase_reg <= phase_reg + 2'h1;
      shift_clk_reg <= ~phase_reg[0] ^ phase_reg[1];
    end
  end
  assign samp_en = phase_reg == codec_pkg::PH_SAMPLE;
  assign bit_en = phase_reg == codec_pkg::PH_BIT;
  assign sync = ctrl_reg[codec_pkg::CB_SYNC];

  // ----------------------------------------
  // transmit and receive counter pairs
  // ----------------------------------------
  assign code_set = word_end && !is_sec_reg;
  conv_timer u_tx_timer (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_base(tx_base_divisor), .i_adj(tx_adjust_value),
    .i_second(tx_second_divisor), .i_code_set(code_set), .i_code(tx_sh_reg[1:0]),
    .o_filter_clk(tx_fclk), .o_conv(tx_conv)
  );
  conv_timer u_rx_timer (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_base(rx_base_divisor), .i_adj(rx_adjust_value),
    .i_second(rx_second_divisor), .i_code_set(code_set), .i_code(tx_sh_reg[1:0]),
    .o_filter_clk(rx_fclk), .o_conv(rx_path_conv)
  );
  assign rx_conv = sync ? tx_conv : rx_path_conv;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_tx_filter_clk <= 1'b0;
      o_rx_filter_clk <= 1'b0;
      o_hp_filter_clk <= 1'b0;
      o_tx_conv <= 1'b0;
      o_rx_conv <= 1'b0;
    end else begin
      o_tx_filter_clk <= tx_fclk;
      o_rx_filter_clk <= sync ? tx_fclk : rx_fclk;
      o_hp_filter_clk <= rx_conv && ctrl_reg[codec_pkg::CB_HPF];
      o_tx_conv <= tx_conv;
      o_rx_conv <= rx_conv;
    end
  end

  // ----------------------------------------
  // transmit frame sequencer
  // ----------------------------------------
  assign tx_start = bit_en && tx_st == codec_pkg::TX_IDLE && tx_pend_reg;
  assign word_end = bit_en && tx_st == codec_pkg::TX_WORD && tx_bits_reg == codec_pkg::LAST_BIT;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      tx_pend_reg <= 1'b0;
    end else if (tx_conv) begin
      tx_pend_reg <= 1'b1;
    end else if (tx_start) begin
      tx_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      tx_st <= codec_pkg::TX_IDLE;
      tx_bits_reg <= 4'h0;
      gap_reg <= 2'h0;
      is_sec_reg <= 1'b0;
      fsx_n_reg <= 1'b1;
    end else if (bit_en) begin
      case (tx_st)
        codec_pkg::TX_IDLE: begin
          if (tx_pend_reg) begin
            tx_st <= codec_pkg::TX_WORD;
            fsx_n_reg <= 1'b0;
            tx_bits_reg <= 4'h0;
            is_sec_reg <= 1'b0;
          end
        end
        codec_pkg::TX_WORD: begin
          if (tx_bits_reg == codec_pkg::LAST_BIT) begin
            fsx_n_reg <= 1'b1;
            gap_reg <= 2'h0;
            if (!is_sec_reg && tx_sh_reg[1:0] == codec_pkg::CODE_SEC) begin
              tx_st <= codec_pkg::TX_GAP;
            end else begin
              tx_st <= codec_pkg::TX_IDLE;
            end
          end else begin
            tx_bits_reg <= tx_bits_reg + 4'h1;
          end
        end
        codec_pkg::TX_GAP: begin
          if (gap_reg == codec_pkg::GAP_LAST) begin
            tx_st <= codec_pkg::TX_WORD;
            fsx_n_reg <= 1'b0;
            tx_bits_reg <= 4'h0;
            is_sec_reg <= 1'b1;
          end else begin
            gap_reg <= gap_reg + 2'h1;
          end
        end
        default: begin
          tx_st <= codec_pkg::TX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      tx_sh_reg <= 16'h0000;
    end else if (samp_en && tx_st == codec_pkg::TX_WORD) begin
      tx_sh_reg <= {tx_sh_reg[14:0], link.serial_data_in};
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_dac_sample <= 14'h0000;
      o_dac_update <= 1'b0;
    end else begin
      o_dac_update <= code_set;
      if (code_set) begin
        o_dac_sample <= tx_sh_reg[15:codec_pkg::DAC_LSB];
      end
    end
  end

  // ----------------------------------------
  // secondary word register writes
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      tx_base_divisor <= codec_pkg::RST_BASE;
      rx_base_divisor <= codec_pkg::RST_BASE;
      tx_adjust_value <= codec_pkg::RST_ADJ;
      rx_adjust_value <= codec_pkg::RST_ADJ;
      tx_second_divisor <= codec_pkg::RST_SECOND;
      rx_second_divisor <= codec_pkg::RST_SECOND;
      ctrl_reg <= codec_pkg::RST_CTRL;
    end else if (word_end && is_sec_reg) begin
      case (tx_sh_reg[1:0])
        codec_pkg::CODE_BASE: begin
          tx_base_divisor <= tx_sh_reg[codec_pkg::TX_FIELD_LSB +: codec_pkg::A_W];
          rx_base_divisor <= tx_sh_reg[codec_pkg::RX_FIELD_LSB +: codec_pkg::A_W];
        end
        codec_pkg::CODE_PLUS: begin
          tx_adjust_value <= tx_sh_reg[codec_pkg::TX_FIELD_LSB +: codec_pkg::ADJ_W];
          rx_adjust_value <= tx_sh_reg[codec_pkg::RX_FIELD_LSB +: codec_pkg::ADJ_W];
        end
        codec_pkg::CODE_MINUS: begin
          tx_second_divisor <= tx_sh_reg[codec_pkg::TX_FIELD_LSB +: codec_pkg::B_W];
          rx_second_divisor <= tx_sh_reg[codec_pkg::RX_FIELD_LSB +: codec_pkg::B_W];
        end
        default: begin
          ctrl_reg <= tx_sh_reg[codec_pkg::CTRL_LSB +: codec_pkg::CTRL_W];
        end
      endcase
    end
  end

  // ----------------------------------------
  // receive frame sequencer
  // ----------------------------------------
  assign rx_start = bit_en && !rx_active_reg && (sync ? tx_start : rx_pend_reg);

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rx_pend_reg <= 1'b0;
    end else if (rx_path_conv && !sync) begin
      rx_pend_reg <= 1'b1;
    end else if (rx_start || sync) begin
      rx_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rx_active_reg <= 1'b0;
      rx_bits_reg <= 4'h0;
      fsr_n_reg <= 1'b1;
      dr_sh_reg <= 16'h0000;
    end else if (rx_start) begin
      rx_active_reg <= 1'b1;
      rx_bits_reg <= 4'h0;
      fsr_n_reg <= 1'b0;
      dr_sh_reg <= i_adc_sample;
    end else if (bit_en && rx_active_reg) begin
      if (rx_bits_reg == codec_pkg::LAST_BIT) begin
        rx_active_reg <= 1'b0;
        fsr_n_reg <= 1'b1;
      end else begin
        rx_bits_reg <= rx_bits_reg + 4'h1;
        dr_sh_reg <= {dr_sh_reg[14:0], 1'b0};
      end
    end
  end

  // ----------------------------------------
  // end of data pulses
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      tx_eod_n_reg <= 1'b1;
      rx_eod_n_reg <= 1'b1;
    end else if (bit_en) begin
      tx_eod_n_reg <= !word_end;
      rx_eod_n_reg <= !(rx_active_reg && rx_bits_reg == codec_pkg::LAST_BIT);
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign link.shift_clock = shift_clk_reg;
  assign link.transmit_frame_sync_n = fsx_n_reg;
  assign link.receive_frame_sync_n = fsr_n_reg;
  assign link.transmit_end_of_data_n = tx_eod_n_reg;
  assign link.receive_end_of_data_n = rx_eod_n_reg;
  assign link.serial_data_out = dr_sh_reg[15];
  assign o_sinx_on = ctrl_reg[codec_pkg::CB_SINX];
  assign o_gain = ctrl_reg[codec_pkg::CB_GAIN_HI:codec_pkg::CB_GAIN_LO];
  assign o_sync_mode = sync;
  assign o_aux_on = ctrl_reg[codec_pkg::CB_AUX];
  assign o_loopback = ctrl_reg[codec_pkg::CB_LOOP];
  assign o_hp_on = ctrl_reg[codec_pkg::CB_HPF];
endmodule // codec_timing
`default_nettype wire

// >>> include/codec_pkg.sv
// shared constants and types for the codec timing block and its dsp port
package codec_pkg;

  // ----------------------------------------
  // shift clock and word timing
  // ----------------------------------------
  localparam logic [1:0] PH_SAMPLE = 2'h1;
  localparam logic [1:0] PH_BIT = 2'h3;
  localparam logic [3:0] LAST_BIT = 4'hF;
  localparam logic [1:0] GAP_LAST = 2'h3;

  // ----------------------------------------
  // control codes in d1..d0
  // ----------------------------------------
  localparam logic [1:0] CODE_BASE = 2'h0;
  localparam logic [1:0] CODE_PLUS = 2'h1;
  localparam logic [1:0] CODE_MINUS = 2'h2;
  localparam logic [1:0] CODE_SEC = 2'h3;

  // ----------------------------------------
  // field widths and positions
  // ----------------------------------------
  localparam int A_W = 5;
  localparam int ADJ_W = 6;
  localparam int B_W = 6;
  localparam int CNT_A_W = 7;
  localparam int TX_FIELD_LSB = 9;
  localparam int RX_FIELD_LSB = 2;
  localparam int DAC_LSB = 2;
  localparam int DAC_W = 14;
  localparam int CTRL_LSB = 2;
  localparam int CTRL_W = 8;
  localparam int CB_HPF = 0;
  localparam int CB_LOOP = 1;
  localparam int CB_AUX = 2;
  localparam int CB_SYNC = 3;
  localparam int CB_GAIN_LO = 4;
  localparam int CB_GAIN_HI = 5;
  localparam int CB_SINX = 7;
  localparam logic [7:0] MOD64 = 8'h40;

  // ----------------------------------------
  // values after reset
  // ----------------------------------------
  localparam logic [4:0] RST_BASE = 5'h09;
  localparam logic [5:0] RST_ADJ = 6'h01;
  localparam logic [5:0] RST_SECOND = 6'h24;
  localparam logic [7:0] RST_CTRL = 8'hB9;

  // ----------------------------------------
  // dsp side register map
  // ----------------------------------------
  localparam logic [3:0] OFS_TX_WORD = 4'h0;
  localparam logic [3:0] OFS_SEC_WORD = 4'h4;
  localparam logic [3:0] OFS_RX_WORD = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hC;
  localparam int ST_RX_VALID = 0;
  localparam int ST_TX_TAKEN = 1;

  typedef enum {TX_IDLE, TX_WORD, TX_GAP} tx_state_t;

endpackage

// >>> include/codec_link_if.sv
// serial link between the codec and the dsp serial port
`timescale 1ns/100ps
`default_nettype none
interface codec_link_if;
  logic shift_clock;
  logic transmit_frame_sync_n;
  logic receive_frame_sync_n;
  logic transmit_end_of_data_n;
  logic receive_end_of_data_n;
  logic serial_data_in;
  logic serial_data_out;

  modport codec (
    output shift_clock, transmit_frame_sync_n, receive_frame_sync_n,
    output transmit_end_of_data_n, receive_end_of_data_n, serial_data_out,
    input serial_data_in
  );
  modport dsp (
    input shift_clock, transmit_frame_sync_n, receive_frame_sync_n,
    input transmit_end_of_data_n, receive_end_of_data_n, serial_data_out,
    output serial_data_in
  );
endinterface
`default_nettype wire

// >>> verilog/dsp_serial_port.sv
// dsp serial port end of the codec link with an ahb-lite register slave
`timescale 1ns/100ps
`default_nettype none
module dsp_serial_port (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // serial link
  codec_link_if.dsp link,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata
);
  logic sclk_d_reg, fsx_d_reg, fsr_d_reg;
  logic fall, fsx_rise, fsr_rise;
  logic [15:0] tx_sh_reg, rx_sh_reg, tx_word_reg, sec_word_reg, rx_word_reg;
  logic sec_next_reg, rx_valid_reg, tx_taken_reg;
  logic acc, wr_pend_reg, rd_rx;
  logic [3:0] wr_ofs_reg;

  // ----------------------------------------
  // link edge detection
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sclk_d_reg <= 1'b1;
      fsx_d_reg <= 1'b1;
      fsr_d_reg <= 1'b1;
    end else begin
      sclk_d_reg <= link.shift_clock;
      fsx_d_reg <= link.transmit_frame_sync_n;
      fsr_d_reg <= link.receive_frame_sync_n;
    end
  end
  assign fall = sclk_d_reg && !link.shift_clock;
  assign fsx_rise = !fsx_d_reg && link.transmit_frame_sync_n;
  assign fsr_rise = !fsr_d_reg && link.receive_frame_sync_n;

  // ----------------------------------------
  // transmit shifter, secondary follows code 11
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      tx_sh_reg <= 16'h0000;
      sec_next_reg <= 1'b0;
    end else if (fsx_rise) begin
      if (sec_next_reg) begin
        tx_sh_reg <= sec_word_reg;
        sec_next_reg <= 1'b0;
      end else begin
        tx_sh_reg <= tx_word_reg;
        sec_next_reg <= tx_word_reg[1:0] == codec_pkg::CODE_SEC;
      end
    end else if (fall && !link.transmit_frame_sync_n) begin
      tx_sh_reg <= {tx_sh_reg[14:0], 1'b0};
    end
  end
  assign link.serial_data_in = tx_sh_reg[15];

  // ----------------------------------------
  // receive shifter
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rx_sh_reg <= 16'h0000;
      rx_word_reg <= 16'h0000;
    end else if (fsr_rise) begin
      rx_word_reg <= rx_sh_reg;
    end else if (fall && !link.receive_frame_sync_n) begin
      rx_sh_reg <= {rx_sh_reg[14:0], link.serial_data_out};
    end
  end

  // ----------------------------------------
  // ahb-lite register slave
  // ----------------------------------------
  assign acc = hsel && hready && htrans[1];
  assign rd_rx = acc && !hwrite && haddr[7:0] == {4'h0, codec_pkg::OFS_RX_WORD};
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      wr_pend_reg <= 1'b0;
      wr_ofs_reg <= 4'h0;
      hrdata <= 32'h00000000;
    end else begin
      wr_pend_reg <= acc && hwrite && haddr[7:4] == 4'h0;
      if (acc) begin
        wr_ofs_reg <= haddr[3:0];
      end
      if (acc && !hwrite) begin
        case (haddr[7:0])
          {4'h0, codec_pkg::OFS_TX_WORD}: hrdata <= {16'h0000, tx_word_reg};
          {4'h0, codec_pkg::OFS_SEC_WORD}: hrdata <= {16'h0000, sec_word_reg};
          {4'h0, codec_pkg::OFS_RX_WORD}: hrdata <= {16'h0000, rx_word_reg};
          {4'h0, codec_pkg::OFS_STATUS}: hrdata <= {30'h00000000, tx_taken_reg, rx_valid_reg};
          default: hrdata <= 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      tx_word_reg <= 16'h0000;
      sec_word_reg <= 16'h0000;
    end else if (wr_pend_reg) begin
      if (wr_ofs_reg == codec_pkg::OFS_TX_WORD) begin
        tx_word_reg <= hwdata[15:0];
      end
      if (wr_ofs_reg == codec_pkg::OFS_SEC_WORD) begin
        sec_word_reg <= hwdata[15:0];
      end
    end
  end

  // sticky flags, a set wins over a clear
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rx_valid_reg <= 1'b0;
      tx_taken_reg <= 1'b0;
    end else begin
      if (fsr_rise) begin
        rx_valid_reg <= 1'b1;
      end else if (rd_rx) begin
        rx_valid_reg <= 1'b0;
      end
      if (fsx_rise && !sec_next_reg) begin
        tx_taken_reg <= 1'b1;
      end else if (wr_pend_reg && wr_ofs_reg == codec_pkg::OFS_TX_WORD) begin
        tx_taken_reg <= 1'b0;
      end
    end
  end
endmodule // dsp_serial_port
`default_nettype wire

// >>> tb/codec_link_chk.sv
// assertions on the codec serial link
`timescale 1ns/100ps
`default_nettype none
module codec_link_chk (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // serial link
  input wire logic shift_clock,
  input wire logic transmit_frame_sync_n,
  input wire logic receive_frame_sync_n,
  input wire logic transmit_end_of_data_n,
  input wire logic receive_end_of_data_n,
  input wire logic serial_data_in,
  input wire logic serial_data_out
);
  wire sc = shift_clock;
  wire fx = transmit_frame_sync_n;
  wire fr = receive_frame_sync_n;
  wire ex = transmit_end_of_data_n;
  wire er = receive_end_of_data_n;
  logic [6:0] xl_reg, rl_reg, xh_reg;
  // ----------
  // frame low and gap high counters
  // ----------
  always_ff @(posedge i_clk) xl_reg <= (!i_rst_n || fx) ? 7'h00 : xl_reg + 7'h01;
  always_ff @(posedge i_clk) rl_reg <= (!i_rst_n || fr) ? 7'h00 : rl_reg + 7'h01;
  always_ff @(posedge i_clk) xh_reg <= (!i_rst_n || !fx) ? 7'h00 : xh_reg + {6'h00, xh_reg != 7'h7F};
  // ----------
  // link properties
  // ----------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  AST_SHIFT_DIV: assert property ($rose(sc) |-> sc [*2] ##1 !sc [*2] ##1 sc)
    else $error("shift clock period wrong");
  AST_TX_LEN: assert property ($rose(fx) |-> xl_reg == 7'h40)
    else $error("transmit frame length wrong");
  AST_RX_LEN: assert property ($rose(fr) |-> rl_reg == 7'h40)
    else $error("receive frame length wrong");
  AST_TX_EOD: assert property ($rose(fx) |-> ##[0:4] $fell(ex))
    else $error("no transmit end pulse");
  AST_RX_EOD: assert property ($rose(fr) |-> ##[0:4] $fell(er))
    else $error("no receive end pulse");
  AST_TX_EOD_W: assert property ($fell(ex) |-> (fx && !ex) [*4] ##1 ex)
    else $error("transmit end pulse shape wrong");
  AST_RX_EOD_W: assert property ($fell(er) |-> (fr && !er) [*4] ##1 er)
    else $error("receive end pulse shape wrong");
  AST_SEC_GAP: assert property ($fell(fx) |-> xh_reg >= 7'h10)
    else $error("transmit frame gap too short");
  AST_DX_HOLD: assert property (!fx && sc && $past(sc) |-> $stable(serial_data_in))
    else $error("data changed while shift clock high");
endmodule // codec_link_chk
`default_nettype wire

// >>> tb/codec_conversion_timing_serial_tb.sv
// bench for codec timing and dsp port joined by the link
`timescale 1ns/100ps
`default_nettype none
module codec_conversion_timing_serial_tb;
  logic i_clk = 1'b0, i_rst_n = 1'b0, hwrite = 1'b0, hrdy, upd, txc, rxc, r, q, tfc, rfc, hpc;
  logic [1:0] htrans = 2'h0;
  logic [13:0] dac;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  wire logic [6:0] cfg;
  int n_fail = 0, samples_checked = 0, n, m;
  codec_link_if lk ();
  codec_timing i_codec_timing (.i_clk(i_clk), .i_rst_n(i_rst_n), .link(lk.codec), .i_adc_sample(16'hC35A),
    .o_dac_sample(dac), .o_dac_update(upd), .o_tx_conv(txc), .o_rx_conv(rxc), .o_tx_filter_clk(tfc),
    .o_rx_filter_clk(rfc), .o_hp_filter_clk(hpc), .o_sinx_on(cfg[6]), .o_gain(cfg[5:4]), .o_sync_mode(cfg[3]),
    .o_aux_on(cfg[2]), .o_loopback(cfg[1]), .o_hp_on(cfg[0]));
  dsp_serial_port i_dsp_serial_port (.i_clk(i_clk), .i_rst_n(i_rst_n), .link(lk.dsp), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy),
    .hreadyout(hrdy), .hresp(), .hrdata(hrdata));
  codec_link_chk i_codec_link_chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .shift_clock(lk.shift_clock),
    .transmit_frame_sync_n(lk.transmit_frame_sync_n), .receive_frame_sync_n(lk.receive_frame_sync_n),
    .transmit_end_of_data_n(lk.transmit_end_of_data_n), .receive_end_of_data_n(lk.receive_end_of_data_n),
    .serial_data_in(lk.serial_data_in), .serial_data_out(lk.serial_data_out));
  always #2 i_clk = ~i_clk;
  // ----------
  // shared tasks
  // ----------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %0h, expected %0h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    if (n_fail == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge i_clk); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge i_clk); while (hrdy !== 1'b1);
    rd = hrdata;
  endtask
  task automatic period;
    @(negedge i_clk iff txc === 1'b1);
    n = 0;
    do begin
      @(negedge i_clk);
      n++;
    end while (txc !== 1'b1);
    chk(rxc, 1'b1);
    chk(hpc, 1'b1);
  endtask
  task automatic gap(output int g, output logic s);
    @(negedge i_clk iff lk.transmit_frame_sync_n === 1'b0);
    @(negedge i_clk iff lk.transmit_frame_sync_n === 1'b1);
    g = 0;
    do begin
      @(negedge i_clk);
      g++;
    end while (lk.transmit_frame_sync_n !== 1'b0);
    s = lk.receive_frame_sync_n;
  endtask
  task automatic send(input logic [15:0] w, input int p);
    ahb(1'b1, 8'h00, {16'h0, w});
    repeat (3) @(negedge i_clk iff upd === 1'b1);
    chk(dac, w[15:2]);
    period;
    period;
    chk(n, p);
  endtask
  // ----------
  // scenarios
  // ----------
  task automatic sc_reset;
    ahb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    chk(cfg, 7'h79);
  endtask
  task automatic sc_fclk;
    @(negedge i_clk iff tfc === 1'b0);
    @(negedge i_clk iff tfc === 1'b1);
    n = 0;
    do begin
      @(negedge i_clk);
      n++;
    end while (tfc !== 1'b0);
    chk(n, codec_pkg::RST_BASE);
    chk(rfc, tfc);
  endtask
  task automatic sc_rx;
    do ahb(1'b0, 8'h0C, 32'h0); while (rd[0] !== 1'b1);
    chk(rd[1], 1'b1);
    ahb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h0000C35A);
  endtask
  task automatic sc_sec;
    ahb(1'b1, 8'h04, 32'h000002BF);
    send(16'h1237, 648);
    chk(cfg, 7'h6F);
    gap(n, r);
    gap(m, q);
    if (n != 16) begin
      n = m;
      r = q;
    end
    chk(n, 16);
    chk(r, 1'b1);
    send(16'h0000, 648);
  endtask
  task automatic sc_async;
    ahb(1'b1, 8'h04, 32'h0000029F);
    send(16'h0003, 648);
    chk(cfg, 7'h67);
    ahb(1'b0, 8'h08, 32'h0);
    do ahb(1'b0, 8'h0C, 32'h0); while (rd[0] !== 1'b1);
    ahb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h0000C35A);
  endtask
  initial begin
    repeat (12) @(posedge i_clk);
    i_rst_n <= 1'b1;
    sc_reset;
    sc_fclk;
    sc_rx;
    send(16'hA5A4, 648);
    send(16'h5A59, 649);
    send(16'h3C3E, 647);
    sc_sec;
    sc_async;
    wrap_up;
  end
  initial begin
    repeat (60000) @(posedge i_clk);
    n_fail++;
    wrap_up;
  end
endmodule // codec_conversion_timing_serial_tb
`default_nettype wire
